// ### design/cdd_decoder.sv
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/100ps
module cdd_decoder #(
   parameter int unsigned CLEAR_CYCLES = cdd_pkg::CLEAR_CYCLES
) (
   input  wire logic               ref_clk,
   input  wire logic               rst_n,
   input  wire logic               reg_addr,
   input  wire logic [7:0]         reg_wdata,
   input  wire logic               reg_wr,
   input  wire logic               reg_rd,
   output      logic [7:0]         reg_rdata,
   output      cdd_pkg::cdd_ctrl_type ctrl,
   output      logic [6:0]         address_counter,
   output      logic [6:0]         display_shift,
   output      logic               busy_indication,
   output      cdd_pkg::cdd_ram_type ram,
   input  wire logic [7:0]         ram_rdata
);
   import cdd_pkg::*;

   cdd_state_type    state;
   logic [CNT_W-1:0] busy_cnt;
   logic             step_pend;
   logic [6:0]       fill_addr;
   logic             fill_left;
   logic             func_done;
   logic             nib_phase;
   logic [3:0]       nib_hi;
   cdd_instr_type    cls;
   logic             nib_mode;
   logic             wr_ok;
   logic             byte_done;
   logic [7:0]       wbyte;
   logic             allowed;
   logic             instr_go;
   logic             clear_go;
   logic             data_wr_go;
   logic             data_rd_ok;
   logic             data_rd_go;
   logic             stat_rd;
   logic             exec_end;
   logic [7:0]       status_byte;

   assign busy_indication = (state != ST_IDLE);
   assign nib_mode        = ~ctrl.interface_width;
   assign wr_ok           = reg_wr & ~busy_indication;
   assign byte_done       = wr_ok & (~nib_mode | nib_phase);
   assign wbyte           = nib_mode ? {nib_hi, reg_wdata[7:4]} : reg_wdata;
   assign instr_go        = byte_done & (reg_addr == ADDR_INSTR) & allowed;
   assign clear_go        = instr_go & (cls == I_CLEAR);
   assign data_wr_go      = byte_done & (reg_addr == ADDR_DATA);
   assign data_rd_ok      = reg_rd & (reg_addr == ADDR_DATA) & ~busy_indication;
   assign data_rd_go      = data_rd_ok & (~nib_mode | nib_phase);
   assign stat_rd         = reg_rd & (reg_addr == ADDR_INSTR);
   assign exec_end        = (state == ST_EXEC) && (busy_cnt == '0);
   assign status_byte     = {busy_indication, address_counter};

   // highest set bit names the instruction, except bit 4, where bits 1:0 pick shift (00) or mode (11)
   always_comb begin
      casez (wbyte)
         8'b1???????: cls = I_DDADDR;
         8'b01??????: cls = I_CGADDR;
         8'b001?????: cls = I_FUNC;
         8'b0001??00: cls = I_SHIFT;
         8'b0001??11: cls = I_MODE;
         8'b00001???: cls = I_DISP;
         8'b000001??: cls = I_ENTRY;
         8'b0000001?: cls = I_HOME;
         8'b00000001: cls = I_CLEAR;
         default:     cls = I_NONE;
      endcase
   end

   // until the first function set no other instruction takes effect; later
   // function sets pass only when they flip the width
   always_comb begin
      if (!func_done) begin
         allowed = (cls == I_FUNC);
      end else begin
         allowed = (cls != I_FUNC) || (wbyte[BIT_WIDTH] != ctrl.interface_width);
      end
   end

   function automatic logic [6:0] ac_step(input logic [6:0] a, input logic up,
                                          input logic two, input logic cg);
      logic [6:0] r;
      r = a;
      if (cg) begin
         r = {1'b0, up ? a[5:0] + 6'h01 : a[5:0] - 6'h01};
      end else if (two) begin
         if (up) begin
            r = (a == L1_LAST) ? L2_FIRST : (a == L2_LAST) ? 7'h00 : a + 7'h01;
         end else begin
            r = (a == 7'h00) ? L2_LAST : (a == L2_FIRST) ? L1_LAST : a - 7'h01;
         end
      end else begin
         if (up) begin
            r = (a == ONE_LAST) ? 7'h00 : a + 7'h01;
         end else begin
            r = (a == 7'h00) ? ONE_LAST : a - 7'h01;
         end
      end
      return r;
   endfunction : ac_step

   // both lines share one offset, so a line never slides into the other
   function automatic logic [6:0] shift_step(input logic [6:0] s, input logic left,
                                             input logic two);
      logic [6:0] lim;
      logic [6:0] r;
      lim = two ? SHIFT_MAX_TWO : SHIFT_MAX_ONE;
      if (left) begin
         r = (s >= lim) ? 7'h00 : s + 7'h01;
      end else begin
         r = (s == 7'h00) ? lim : s - 7'h01;
      end
      return r;
   endfunction : shift_step

   // nibble pairing in four-bit mode: high nibble first
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         nib_phase <= 1'b0;
         nib_hi    <= 4'h0;
      end else if (instr_go && cls == I_FUNC) begin
         nib_phase <= 1'b0;
         nib_hi    <= 4'h0;
      end else if (nib_mode && (wr_ok || data_rd_ok || stat_rd)) begin
         nib_phase <= ~nib_phase;
         if (wr_ok) begin
            nib_hi <= reg_wdata[7:4];
         end
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (stat_rd) begin
         if (!nib_mode) begin
            reg_rdata <= status_byte;
         end else begin
            reg_rdata <= nib_phase ? {status_byte[3:0], 4'h0} : {status_byte[7:4], 4'h0};
         end
      end else if (data_rd_ok) begin
         if (!nib_mode) begin
            reg_rdata <= ram_rdata;
         end else begin
            reg_rdata <= nib_phase ? {ram_rdata[3:0], 4'h0} : {ram_rdata[7:4], 4'h0};
         end
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // busy sequencing
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state     <= ST_IDLE;
         busy_cnt  <= '0;
         step_pend <= 1'b0;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (clear_go) begin
                  state    <= ST_CLEAR;
                  busy_cnt <= CNT_W'(CLEAR_CYCLES - 1);
               end else if (instr_go || data_wr_go || data_rd_go) begin
                  state     <= ST_EXEC;
                  busy_cnt  <= CNT_W'(EXEC_CYCLES - 1);
                  step_pend <= data_wr_go | data_rd_go;
               end
            end
            ST_EXEC: begin
               if (busy_cnt == '0) begin
                  state     <= ST_IDLE;
                  step_pend <= 1'b0;
               end else begin
                  busy_cnt <= busy_cnt - 1'b1;
               end
            end
            ST_CLEAR: begin
               // the fill must also be done if the time was shortened
               if (busy_cnt == '0 && !fill_left) begin
                  state <= ST_IDLE;
               end else if (busy_cnt != '0) begin
                  busy_cnt <= busy_cnt - 1'b1;
               end
            end
         endcase
      end
   end

   // ram port: blank fill during clear, otherwise data writes at the counter
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ram       <= '0;
         fill_addr <= 7'h00;
         fill_left <= 1'b0;
      end else if (clear_go) begin
         ram.we    <= 1'b0;
         fill_addr <= 7'h00;
         fill_left <= 1'b1;
      end else if (fill_left) begin
         ram.we    <= 1'b1;
         ram.cg    <= 1'b0;
         ram.addr  <= fill_addr;
         ram.wdata <= BLANK_CHAR;
         fill_addr <= fill_addr + 7'h01;
         fill_left <= (fill_addr != FILL_LAST);
      end else begin
         ram.we    <= data_wr_go;
         ram.cg    <= ctrl.cg_select;
         // follow the step at once, so a read straight after busy sees the new cell
         ram.addr  <= (exec_end && step_pend) ? ac_step(address_counter, ctrl.inc_dir,
                      ctrl.two_line, ctrl.cg_select) : address_counter;
         ram.wdata <= wbyte;
      end
   end

   // counter: data accesses step it once busy ends, instructions load it
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         address_counter <= 7'h00;
      end else if (exec_end && step_pend) begin
         address_counter <= ac_step(address_counter, ctrl.inc_dir, ctrl.two_line,
                                    ctrl.cg_select);
      end else if (instr_go) begin
         unique case (cls)
            I_CLEAR: begin
               address_counter <= 7'h00;
            end
            I_HOME: begin
               address_counter <= 7'h00;
            end
            I_SHIFT: begin
               // a display shift leaves the counter where it is
               if (!wbyte[BIT_SC]) begin
                  address_counter <= ac_step(address_counter, wbyte[BIT_RL],
                                             ctrl.two_line, ctrl.cg_select);
               end
            end
            I_CGADDR: begin
               address_counter <= {1'b0, wbyte[5:0]};
            end
            I_DDADDR: begin
               // out-of-range addresses are the host's problem and load as given
               address_counter <= wbyte[6:0];
            end
            I_ENTRY, I_DISP, I_MODE, I_FUNC, I_NONE: begin
               address_counter <= address_counter;
            end
         endcase
      end
   end

   // display offset: moved by data accesses with shift on, or by the shift instruction
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         display_shift <= 7'h00;
      end else if (exec_end && step_pend) begin
         // cg ram accesses never move the picture
         if (ctrl.shift_en && !ctrl.cg_select) begin
            display_shift <= shift_step(display_shift, ctrl.inc_dir, ctrl.two_line);
         end
      end else if (instr_go) begin
         unique case (cls)
            I_CLEAR, I_HOME: begin
               display_shift <= 7'h00;
            end
            I_SHIFT: begin
               if (wbyte[BIT_SC]) begin
                  // counter untouched, the cursor rides along with the offset
                  display_shift <= shift_step(display_shift, ~wbyte[BIT_RL],
                                              ctrl.two_line);
               end
            end
            I_ENTRY, I_DISP, I_MODE, I_FUNC, I_CGADDR, I_DDADDR, I_NONE: begin
               display_shift <= display_shift;
            end
         endcase
      end
   end

   // control bits latched by the instructions
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= CTRL_RESET;
      end else if (instr_go) begin
         unique case (cls)
            I_CLEAR: begin
               ctrl.cg_select <= 1'b0;
               ctrl.inc_dir   <= 1'b1;
            end
            I_HOME: begin
               ctrl.cg_select <= 1'b0;
            end
            I_ENTRY: begin
               ctrl.inc_dir  <= wbyte[BIT_ID];
               ctrl.shift_en <= wbyte[BIT_SH];
            end
            I_DISP: begin
               ctrl.display_on   <= wbyte[BIT_DISP];
               ctrl.cursor_on    <= wbyte[BIT_CUR];
               ctrl.cursor_blink <= wbyte[BIT_BLINK];
            end
            I_MODE: begin
               ctrl.graphic_mode <= wbyte[BIT_GC];
               ctrl.power_on     <= wbyte[BIT_PWR];
            end
            I_FUNC: begin
               ctrl.interface_width <= wbyte[BIT_WIDTH];
               ctrl.two_line        <= wbyte[BIT_LINES];
               ctrl.tall_font       <= wbyte[BIT_FONT];
               // the unavailable table code keeps the table already chosen
               if (wbyte[1:0] != FT_NONE) begin
                  ctrl.font_table <= wbyte[1:0];
               end
            end
            I_CGADDR: begin
               ctrl.cg_select <= 1'b1;
            end
            I_DDADDR: begin
               ctrl.cg_select <= 1'b0;
            end
            I_SHIFT, I_NONE: begin
               ctrl <= ctrl;
            end
         endcase
      end
   end

   // set by the first accepted function set, held until reset
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         func_done <= 1'b0;
      end else if (instr_go && cls == I_FUNC) begin
         func_done <= 1'b1;
      end
   end

endmodule : cdd_decoder

// ### design/cdd_pkg.sv
package cdd_pkg;

   // register select values seen on the one-bit address
   localparam logic       ADDR_INSTR    = 1'b0;
   localparam logic       ADDR_DATA     = 1'b1;

   // timing
   localparam int         CLK_PERIOD_NS = 4;
   localparam int         CLEAR_TIME_US = 6200;
   localparam int         CLEAR_CYCLES  = CLEAR_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int         EXEC_CYCLES   = 1;
   localparam int         CNT_W         = 21;

   // display data ram layout
   localparam logic [7:0] BLANK_CHAR    = 8'h20;
   localparam logic [6:0] ONE_LAST      = 7'h4f;
   localparam logic [6:0] L1_LAST       = 7'h27;
   localparam logic [6:0] L2_FIRST      = 7'h40;
   localparam logic [6:0] L2_LAST       = 7'h67;
   localparam logic [6:0] FILL_LAST     = 7'h7f;
   localparam logic [6:0] SHIFT_MAX_TWO = 7'h27;
   localparam logic [6:0] SHIFT_MAX_ONE = 7'h4f;

   // instruction field positions
   localparam int         BIT_ID        = 1;
   localparam int         BIT_SH        = 0;
   localparam int         BIT_DISP      = 2;
   localparam int         BIT_CUR       = 1;
   localparam int         BIT_BLINK     = 0;
   localparam int         BIT_SC        = 3;
   localparam int         BIT_RL        = 2;
   localparam int         BIT_GC        = 3;
   localparam int         BIT_PWR       = 2;
   localparam int         BIT_WIDTH     = 4;
   localparam int         BIT_LINES     = 3;
   localparam int         BIT_FONT      = 2;
   localparam logic [1:0] FT_NONE       = 2'h3;

   typedef enum logic [3:0] {
      I_NONE, I_CLEAR, I_HOME, I_ENTRY, I_DISP, I_SHIFT, I_MODE, I_FUNC, I_CGADDR,
      I_DDADDR
   } cdd_instr_type;

   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_CLEAR} cdd_state_type;

   typedef struct packed {
      logic       display_on;
      logic       cursor_on;
      logic       cursor_blink;
      logic       graphic_mode;
      logic       power_on;
      logic       interface_width;
      logic       two_line;
      logic       tall_font;
      logic [1:0] font_table;
      logic       inc_dir;
      logic       shift_en;
      logic       cg_select;
   } cdd_ctrl_type;

   typedef struct packed {
      logic       we;
      logic       cg;
      logic [6:0] addr;
      logic [7:0] wdata;
   } cdd_ram_type;

   localparam cdd_ctrl_type CTRL_RESET = '{
      display_on: 1'b0, cursor_on: 1'b0, cursor_blink: 1'b0, graphic_mode: 1'b0,
      power_on: 1'b0, interface_width: 1'b1, two_line: 1'b0, tall_font: 1'b0,
      font_table: 2'h0, inc_dir: 1'b1, shift_en: 1'b0, cg_select: 1'b0};

endpackage : cdd_pkg

// ### verification/cdd_ram_model.sv
`timescale 1ns/100ps
module cdd_ram_model (
   input  wire cdd_pkg::cdd_ram_type ram,
   input  wire logic                 ref_clk,
   output      logic [7:0]           ram_rdata
);
   import cdd_pkg::*;
   logic [7:0] dd [128];
   logic [7:0] cg [64];
   // async read: the decoder samples it in the read strobe cycle
   assign ram_rdata = ram.cg ? cg[ram.addr[5:0]] : dd[ram.addr];
   always_ff @(posedge ref_clk) begin
      if (ram.we && ram.cg) begin
         cg[ram.addr[5:0]] <= ram.wdata;
      end
      if (ram.we && !ram.cg) begin
         dd[ram.addr] <= ram.wdata;
      end
   end
endmodule : cdd_ram_model

// ### verification/cdd_assertions.sv
`timescale 1ns/100ps
module cdd_checker #(
   parameter int unsigned CLEAR_CYCLES = 200
) (
   input wire logic                  ref_clk,
   input wire logic                  rst_n,
   input wire logic                  reg_addr,
   input wire logic [7:0]            reg_wdata,
   input wire logic                  reg_wr,
   input wire logic                  reg_rd,
   input wire logic [7:0]            reg_rdata,
   input wire cdd_pkg::cdd_ctrl_type ctrl,
   input wire logic [6:0]            address_counter,
   input wire logic [6:0]            display_shift,
   input wire logic                  busy_indication,
   input wire cdd_pkg::cdd_ram_type  ram,
   input wire logic [7:0]            ram_rdata
);
   import cdd_pkg::*;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // an executed write shows as busy one cycle later; 8-bit mode only
   sequence ins_s(logic c);
      reg_wr && reg_addr == ADDR_INSTR && !busy_indication && ctrl.interface_width && c
      ##1 busy_indication;
   endsequence
   sequence dwr_s;
      reg_wr && reg_addr == ADDR_DATA && !busy_indication && ctrl.interface_width
      ##1 busy_indication;
   endsequence
   logic [31:0] clr_len;
   // cycles since an accepted clear, so its busy time can be measured
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         clr_len <= 32'h0;
      end else if (reg_wr && reg_addr == ADDR_INSTR && !busy_indication &&
                   reg_wdata == 8'h01 && ctrl.interface_width) begin
         clr_len <= 32'h1;
      end else if (busy_indication && clr_len != 32'h0) begin
         clr_len <= clr_len + 32'h1;
      end else begin
         clr_len <= 32'h0;
      end
   end
   stat_read_a: assert property (reg_rd && reg_addr == ADDR_INSTR &&
      ctrl.interface_width |=> reg_rdata == {$past(busy_indication), $past(address_counter)})
      else $error("bad status");
   rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("rdata not 0");
   clear_exec_a: assert property (ins_s(reg_wdata == 8'h01) |->
      address_counter == 7'h00 && display_shift == 7'h00 && ctrl.inc_dir &&
      $stable(ctrl.shift_en)) else $error("bad clear");
   home_exec_a: assert property (ins_s(reg_wdata[7:1] == 7'h01) |->
      address_counter == 7'h00 && display_shift == 7'h00 && !ram.we) else $error("bad home");
   clear_time_a: assert property ($fell(busy_indication) && clr_len != 32'h0 |->
      clr_len > CLEAR_CYCLES) else $error("clear busy too short");
   dd_load_a: assert property (ins_s(reg_wdata[7]) |->
      address_counter == $past(reg_wdata[6:0]) && !ctrl.cg_select) else $error("bad dd load");
   cg_load_a: assert property (ins_s(reg_wdata[7:6] == 2'b01) |->
      address_counter == {1'b0, $past(reg_wdata[5:0])} && ctrl.cg_select) else $error("bad cg");
   disp_ctrl_a: assert property (ins_s(reg_wdata[7:3] == 5'h01) |->
      {ctrl.display_on, ctrl.cursor_on, ctrl.cursor_blink} == $past(reg_wdata[2:0]))
      else $error("bad display control");
   busy_reject_a: assert property (busy_indication && reg_wr |=> $stable(ctrl))
      else $error("write taken while busy");
   ram_write_a: assert property (dwr_s |-> ram.we && ram.addr == $past(address_counter) &&
      ram.wdata == $past(reg_wdata)) else $error("bad ram write");
   ac_step_a: assert property (dwr_s ##0
      (!ctrl.cg_select && address_counter inside {[7'h01:7'h1f]}) |=> !busy_indication &&
      address_counter == $past(address_counter) + ($past(ctrl.inc_dir) ? 7'h01 : 7'h7f))
      else $error("bad counter step");
endmodule : cdd_checker
bind cdd_decoder cdd_checker #(.CLEAR_CYCLES(CLEAR_CYCLES)) i_chk (.ref_clk, .rst_n, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ctrl, .address_counter, .display_shift,
   .busy_indication, .ram, .ram_rdata);

// ### verification/tb.sv
`timescale 1ns/100ps
module tb;
   import cdd_pkg::*;
   localparam int unsigned CLR = 200;
   logic         ref_clk   = 1'b0;
   logic         rst_n     = 1'b0;
   logic         reg_addr  = 1'b0;
   logic [7:0]   reg_wdata = 8'h00;
   logic         reg_wr    = 1'b0;
   logic         reg_rd    = 1'b0;
   logic [7:0]   reg_rdata;
   cdd_ctrl_type ctrl;
   logic [6:0]   address_counter;
   logic [6:0]   display_shift;
   logic         busy_indication;
   cdd_ram_type  ram;
   logic [7:0]   ram_rdata;
   logic [7:0]   exq [$];
   logic         pend      = 1'b0;
   int           err_count = 0;
   int           n_tests   = 0;
   int           cyc       = 0;
   int           nb;
   logic [31:0]  seed      = 32'hf00d7ec0;
   logic [6:0]   ac;
   logic [7:0]   d;
   logic [4:0]   fn;
   always #2 ref_clk = ~ref_clk;
   assign fn = {ctrl.interface_width, ctrl.two_line, ctrl.tall_font, ctrl.font_table};
   cdd_decoder #(.CLEAR_CYCLES(CLR)) i_dut (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .ctrl, .address_counter, .display_shift, .busy_indication, .ram,
      .ram_rdata);
   cdd_ram_model i_ram (.ram, .ref_clk, .ram_rdata);
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs
   task automatic results();
      if (err_count == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : results
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // the host polls busy before every wr and rd transfer; bounded so a stuck busy cannot hang
   task automatic idle();
      #1;
      for (int i = 0; i < 400 && busy_indication !== 1'b0; i++) begin
         @(posedge ref_clk);
         #1;
      end
   endtask : idle
   task automatic wr(input logic a, input logic [7:0] v);
      idle();
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
   endtask : wr
   task automatic rd(input logic a, input logic [7:0] e);
      idle();
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      exq.push_back(e);
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
   endtask : rd
   always @(posedge ref_clk) begin
      if (pend) chk("reg_rdata", 16'(exq.pop_front()), 16'(reg_rdata));
      pend <= reg_rd;
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         results();
      end
   end
   initial begin
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      #1;
      chk("ctrl", 16'(CTRL_RESET), 16'(ctrl));
      wr(1'b0, 8'h85);
      rd(1'b0, 8'h00);
      wr(1'b0, 8'h3d);
      wr(1'b0, 8'h33);
      idle();
      chk("func", 16'h1d, 16'(fn));
      wr(1'b0, 8'h2b);
      idle();
      chk("func", 16'h09, 16'(fn));
      wr(1'b0, 8'h30);
      wr(1'b0, 8'h80);
      idle();
      chk("func", 16'h18, 16'(fn));
      for (int v = 0; v < 8; v++) begin
         wr(1'b0, 8'h08 | 8'(v));
         idle();
         chk("disp", 16'(v), 16'({ctrl.display_on, ctrl.cursor_on, ctrl.cursor_blink}));
      end
      for (int v = 0; v < 4; v++) begin
         wr(1'b0, 8'h13 | 8'(v << 2));
         idle();
         chk("mode", 16'(v), 16'({ctrl.graphic_mode, ctrl.power_on}));
      end
      for (int k = 0; k < 4; k++) begin
         seed = xs(seed);
         ac = 7'(seed[7:0] % 8'd38) + 7'd1;
         d = seed[15:8];
         wr(1'b0, {1'b1, ac});
         rd(1'b0, {1'b0, ac});
         wr(1'b0, 8'h06);
         wr(1'b1, d);
         rd(1'b0, {1'b0, ac + 7'd1});
         wr(1'b0, 8'h04);
         wr(1'b1, ~d);
         rd(1'b0, {1'b0, ac});
         wr(1'b0, {1'b1, ac});
         rd(1'b1, d);
         rd(1'b0, {1'b0, ac - 7'd1});
      end
      wr(1'b0, 8'h85);
      wr(1'b0, 8'h07);
      wr(1'b1, 8'h41);
      idle();
      chk("shift", 16'h1, 16'(display_shift));
      wr(1'b0, 8'h10);
      wr(1'b0, 8'h14);
      wr(1'b0, 8'h14);
      rd(1'b0, 8'h07);
      wr(1'b0, 8'h18);
      wr(1'b0, 8'h18);
      wr(1'b0, 8'h1c);
      rd(1'b0, 8'h07);
      idle();
      chk("shift", 16'h2, 16'(display_shift));
      wr(1'b0, 8'h06);
      wr(1'b0, 8'ha7);
      wr(1'b1, 8'h42);
      rd(1'b0, 8'h40);
      wr(1'b0, 8'h7f);
      wr(1'b1, 8'h1f);
      rd(1'b0, 8'h00);
      chk("cg", 16'h1f, 16'(i_ram.cg[63]));
      // second write lands in the busy cycle of the first
      idle();
      @(posedge ref_clk);
      reg_addr  <= 1'b0;
      reg_wdata <= 8'h91;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wdata <= 8'ha2;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
      rd(1'b0, 8'h11);
      wr(1'b0, 8'h03);
      rd(1'b0, 8'h00);
      idle();
      chk("shift", 16'h0, 16'(display_shift));
      chk("dd", 16'h42, 16'(i_ram.dd[7'h27]));
      wr(1'b0, 8'h05);
      wr(1'b0, 8'h01);
      nb = 0;
      #1;
      while (busy_indication === 1'b1 && nb < 1000) begin
         @(posedge ref_clk);
         #1;
         nb++;
      end
      chk("clear_busy", 16'h1, 16'(nb >= CLR));
      chk("entry", 16'h3, 16'({ctrl.inc_dir, ctrl.shift_en}));
      rd(1'b0, 8'h00);
      for (int i = 0; i < 128; i++) chk("dd", 16'h20, 16'(i_ram.dd[i]));
      repeat (4) @(posedge ref_clk);
      results();
   end
endmodule : tb
